// File: logic/cts_defines.svh
// Address map, field positions and reset values of the timer/filter slice.
// Assumes a 16-bit APB byte address and 32-bit data.
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH

`define CTS_ADDR_W 16
`define CTS_DATA_W 32
`define CTS_FIFOS 16
`define CTS_FILTERS 16
`define CTS_IDX_W 4

// Register bases, byte addresses
`define CTS_ADDR_CTRL 16'hb000
`define CTS_ADDR_OVF 16'hb060
`define CTS_ADDR_TMR 16'hb070
`define CTS_ADDR_MASK3 16'hb0b0
`define CTS_ADDR_FC0 16'hb0c0
`define CTS_ADDR_FC1 16'hb0d0
`define CTS_ADDR_FC2 16'hb0e0
`define CTS_ADDR_FC3 16'hb0f0
`define CTS_ADDR_FID0 16'hb140
`define CTS_ADDR_FID_LAST 16'hb23f
`define CTS_ADDR_INT_STAT 16'hb300
`define CTS_ADDR_INT_MASK 16'hb310

// Alias field of the byte address
`define CTS_ALIAS_MSB 3
`define CTS_ALIAS_LSB 2
`define CTS_BASE_MASK 16'hfff3
`define CTS_FID_IDX_MSB 7
`define CTS_FID_IDX_LSB 4

// Field positions
`define CTS_CAP_BIT 20
`define CTS_TS_MSB 31
`define CTS_TS_LSB 16
`define CTS_PRE_MSB 15
`define CTS_PRE_LSB 0
`define CTS_LOW_MSB 15
`define CTS_HIGH_MSB 31
`define CTS_HIGH_LSB 16

// Values
`define CTS_ZERO32 32'h0000_0000
`define CTS_ZERO16 16'h0000
`define CTS_ONE16 16'h0001
`define CTS_TS_MAX 16'hffff

`endif

// File: logic/cts_pkg.sv
// Types shared by the timer/filter register slice.
// Assumes cts_defines.svh supplies the numeric constants.
package cts_pkg;

  typedef enum logic [1:0] {
    cts_alias_base = 2'b00,
    cts_alias_clear = 2'b01,
    cts_alias_set = 2'b10,
    cts_alias_invert = 2'b11
  } cts_alias_type;

  typedef enum logic [3:0] {
    cts_sel_none = 4'h0,
    cts_sel_ctrl = 4'h1,
    cts_sel_ovf = 4'h2,
    cts_sel_tmr = 4'h3,
    cts_sel_mask3 = 4'h4,
    cts_sel_fc = 4'h5,
    cts_sel_fid = 4'h6,
    cts_sel_int_stat = 4'h7,
    cts_sel_int_mask = 4'h8
  } cts_sel_type;

endpackage : cts_pkg

// File: logic/cts_fid_mem.sv
// Filter identifier storage, one word per filter, registered read data.
// Assumes one write port and one read port on the same clock; no reset.
`timescale 1ns/1ns
`include "cts_defines.svh"

module cts_fid_mem #(
  parameter int depth = `CTS_FILTERS,
  parameter int idx_w = `CTS_IDX_W,
  parameter int data_w = `CTS_DATA_W
) (
  input wire logic pclk,
  input wire logic write_en,
  input wire logic [idx_w-1:0] write_idx,
  input wire logic [data_w-1:0] write_data,
  input wire logic [idx_w-1:0] read_idx,
  output logic [data_w-1:0] read_data
);

  logic [data_w-1:0] words [depth];

  // Contents undefined until software writes them
  always_ff @(posedge pclk) begin
    if (write_en) begin
      words[write_idx] <= write_data;
    end
    read_data <= words[read_idx];
  end

endmodule : cts_fid_mem

// File: logic/cts_regs.sv
// APB register slice: time-stamp timer, overflow flags, filter registers.
// Assumes FIFO logic pulses overflow events and releases; one clock pclk.
//
// What this block does
// - Capture enable set: count advances once per prescaler interval.
// - Prescale zero steps every clock; all ones every 65535 clocks.
// - Capture enable clear: count and prescaler count hold still.
// - Any timer register write loads count and prescale and zeroes the prescaler count.
// - Timer word: count in high half, prescale in low, reset zero.
// - Sixteen read-only overflow flags, one per FIFO, reset zero.
// - Upper half of overflow status always reads zero.
// - Clear, set, invert aliases at base plus 0x4, 0x8, 0xC.
// - Filter controls and mask reset zero; identifiers undefined.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "cts_defines.svh"

module cts_regs #(
  parameter int fifos = `CTS_FIFOS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CTS_ADDR_W-1:0] paddr,
  input wire logic [`CTS_DATA_W-1:0] pwdata,
  output logic [`CTS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fifos-1:0] rx_overflow_event,
  input wire logic [fifos-1:0] rx_overflow_release,
  output logic timestamp_capture_enable,
  output logic [15:0] timestamp_count,
  output logic [`CTS_DATA_W-1:0] rx_acceptance_mask_3,
  output logic [4*`CTS_DATA_W-1:0] filter_control,
  output logic irq
);

  function automatic logic [`CTS_DATA_W-1:0] apply_alias(
    input logic [`CTS_DATA_W-1:0] old,
    input logic [`CTS_DATA_W-1:0] data,
    input cts_pkg::cts_alias_type op
  );
    case (op)
      cts_pkg::cts_alias_clear: apply_alias = old & ~data;
      cts_pkg::cts_alias_set: apply_alias = old | data;
      cts_pkg::cts_alias_invert: apply_alias = old ^ data;
      default: apply_alias = data;
    endcase
  endfunction : apply_alias

  // Address decode
  cts_pkg::cts_sel_type sel;
  cts_pkg::cts_alias_type op;
  logic [`CTS_ADDR_W-1:0] base;
  logic [`CTS_ADDR_W-1:0] fid_off;
  logic [1:0] fc_idx;
  logic [`CTS_IDX_W-1:0] fid_idx;

  always_comb begin
    base = paddr & `CTS_BASE_MASK;
    op = cts_pkg::cts_alias_type'(paddr[`CTS_ALIAS_MSB:`CTS_ALIAS_LSB]);
    fid_off = paddr - `CTS_ADDR_FID0;
    fid_idx = fid_off[`CTS_FID_IDX_MSB:`CTS_FID_IDX_LSB];
    fc_idx = 2'b00;
    sel = cts_pkg::cts_sel_none;
    if (paddr >= `CTS_ADDR_FID0 && paddr <= `CTS_ADDR_FID_LAST) begin
      sel = cts_pkg::cts_sel_fid;
    end else begin
      case (base)
        `CTS_ADDR_CTRL: sel = cts_pkg::cts_sel_ctrl;
        `CTS_ADDR_OVF: sel = cts_pkg::cts_sel_ovf;
        `CTS_ADDR_TMR: sel = cts_pkg::cts_sel_tmr;
        `CTS_ADDR_MASK3: sel = cts_pkg::cts_sel_mask3;
        `CTS_ADDR_FC0: sel = cts_pkg::cts_sel_fc;
        `CTS_ADDR_FC1: begin
          sel = cts_pkg::cts_sel_fc;
          fc_idx = 2'b01;
        end
        `CTS_ADDR_FC2: begin
          sel = cts_pkg::cts_sel_fc;
          fc_idx = 2'b10;
        end
        `CTS_ADDR_FC3: begin
          sel = cts_pkg::cts_sel_fc;
          fc_idx = 2'b11;
        end
        `CTS_ADDR_INT_STAT: begin
          if (op == cts_pkg::cts_alias_base) begin
            sel = cts_pkg::cts_sel_int_stat;
          end
        end
        `CTS_ADDR_INT_MASK: begin
          if (op == cts_pkg::cts_alias_base) begin
            sel = cts_pkg::cts_sel_int_mask;
          end
        end
        default: sel = cts_pkg::cts_sel_none;
      endcase
    end
  end

  logic setup;
  logic access;
  logic wr;
  logic rd_setup;
  logic tmr_wr;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = access;
  assign pslverr = access & (sel == cts_pkg::cts_sel_none);
  assign wr = access & pwrite & (sel != cts_pkg::cts_sel_none);
  assign rd_setup = setup & ~pwrite;
  assign tmr_wr = wr & (sel == cts_pkg::cts_sel_tmr);

  // Register state
  logic cap;
  logic [15:0] ts;
  logic [15:0] prescale;
  logic [15:0] presc_cnt;
  logic [fifos-1:0] ovf;
  logic [fifos-1:0] int_stat;
  logic [fifos-1:0] int_mask;
  logic [`CTS_DATA_W-1:0] mask3;
  logic [`CTS_DATA_W-1:0] fc [4];
  logic [`CTS_DATA_W-1:0] rdata_q;
  logic fid_rd_q;

  logic next_cap;
  logic [15:0] next_ts;
  logic [15:0] next_prescale;
  logic [15:0] next_presc_cnt;
  logic [fifos-1:0] next_ovf;
  logic [fifos-1:0] next_int_stat;
  logic [fifos-1:0] next_int_mask;
  logic [`CTS_DATA_W-1:0] next_mask3;
  logic [`CTS_DATA_W-1:0] next_fc [4];
  logic [`CTS_DATA_W-1:0] next_rdata;
  logic next_fid_rd;

  logic [`CTS_DATA_W-1:0] ctrl_word;
  logic [`CTS_DATA_W-1:0] ctrl_new;
  logic [`CTS_DATA_W-1:0] tmr_word;
  logic [`CTS_DATA_W-1:0] new_word;
  logic [`CTS_DATA_W-1:0] fid_rdata;
  logic [15:0] presc_cnt_inc;
  logic tick;

  always_comb begin
    ctrl_word = `CTS_ZERO32;
    ctrl_word[`CTS_CAP_BIT] = cap;
    tmr_word = {ts, prescale};
    ctrl_new = apply_alias(ctrl_word, pwdata, op);
  end

  // Prescaler and time-stamp count
  always_comb begin
    presc_cnt_inc = presc_cnt + `CTS_ONE16;
    tick = (prescale == `CTS_ZERO16) || (presc_cnt_inc >= prescale);
    next_ts = ts;
    next_prescale = prescale;
    next_presc_cnt = presc_cnt;
    if (tmr_wr) begin
      new_word = apply_alias(tmr_word, pwdata, op);
      next_ts = new_word[`CTS_TS_MSB:`CTS_TS_LSB];
      next_prescale = new_word[`CTS_PRE_MSB:`CTS_PRE_LSB];
      next_presc_cnt = `CTS_ZERO16;
    end else begin
      new_word = `CTS_ZERO32;
      if (cap) begin
        if (tick) begin
          next_presc_cnt = `CTS_ZERO16;
          next_ts = ts + `CTS_ONE16;
        end else begin
          next_presc_cnt = presc_cnt_inc;
        end
      end
    end
  end

  // Control, filter and interrupt registers
  always_comb begin
    next_cap = cap;
    next_mask3 = mask3;
    next_int_mask = int_mask;
    for (int i = 0; i < 4; i++) begin
      next_fc[i] = fc[i];
    end
    if (wr) begin
      case (sel)
        cts_pkg::cts_sel_ctrl: next_cap = ctrl_new[`CTS_CAP_BIT];
        cts_pkg::cts_sel_mask3: next_mask3 = apply_alias(mask3, pwdata, op);
        cts_pkg::cts_sel_fc: begin
          next_fc[fc_idx] = apply_alias(fc[fc_idx], pwdata, op);
        end
        cts_pkg::cts_sel_int_mask: next_int_mask = pwdata[fifos-1:0];
        default: next_cap = cap;
      endcase
    end
  end

  // Overflow flags and interrupt status: a set beats a same-cycle clear
  generate
    for (genvar g = 0; g < fifos; g++) begin : g_fifo
      always_comb begin
        next_ovf[g] = rx_overflow_event[g] |
          (ovf[g] & ~rx_overflow_release[g]);
        next_int_stat[g] = rx_overflow_event[g] | (int_stat[g] &
          ~(wr & (sel == cts_pkg::cts_sel_int_stat) & pwdata[g]));
      end
    end
  endgenerate

  // Read data captured in the setup cycle
  always_comb begin
    next_rdata = rdata_q;
    next_fid_rd = 1'b0;
    if (rd_setup) begin
      case (sel)
        cts_pkg::cts_sel_ctrl: next_rdata = ctrl_word;
        cts_pkg::cts_sel_ovf: begin
          next_rdata = `CTS_ZERO32;
          next_rdata[fifos-1:0] = ovf;
        end
        cts_pkg::cts_sel_tmr: next_rdata = tmr_word;
        cts_pkg::cts_sel_mask3: next_rdata = mask3;
        cts_pkg::cts_sel_fc: next_rdata = fc[fc_idx];
        cts_pkg::cts_sel_fid: next_fid_rd = 1'b1;
        cts_pkg::cts_sel_int_stat: begin
          next_rdata = `CTS_ZERO32;
          next_rdata[fifos-1:0] = int_stat;
        end
        cts_pkg::cts_sel_int_mask: begin
          next_rdata = `CTS_ZERO32;
          next_rdata[fifos-1:0] = int_mask;
        end
        default: next_rdata = `CTS_ZERO32;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 1'b0;
      ts <= `CTS_ZERO16;
      prescale <= `CTS_ZERO16;
      presc_cnt <= `CTS_ZERO16;
      ovf <= '0;
      int_stat <= '0;
      int_mask <= '0;
      mask3 <= `CTS_ZERO32;
      for (int i = 0; i < 4; i++) begin
        fc[i] <= `CTS_ZERO32;
      end
      rdata_q <= `CTS_ZERO32;
      fid_rd_q <= 1'b0;
    end else begin
      cap <= next_cap;
      ts <= next_ts;
      prescale <= next_prescale;
      presc_cnt <= next_presc_cnt;
      ovf <= next_ovf;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      mask3 <= next_mask3;
      for (int i = 0; i < 4; i++) begin
        fc[i] <= next_fc[i];
      end
      rdata_q <= next_rdata;
      fid_rd_q <= next_fid_rd;
    end
  end

  // Identifier words; old value is on read_data during the access cycle
  cts_fid_mem #(
    .depth(`CTS_FILTERS),
    .idx_w(`CTS_IDX_W),
    .data_w(`CTS_DATA_W)
  ) u_fid_mem (
    .pclk(pclk),
    .write_en(wr & (sel == cts_pkg::cts_sel_fid)),
    .write_idx(fid_idx),
    .write_data(apply_alias(fid_rdata, pwdata, op)),
    .read_idx(fid_idx),
    .read_data(fid_rdata)
  );

  assign prdata = fid_rd_q ? fid_rdata : rdata_q;
  assign irq = |(int_stat & int_mask);
  assign timestamp_capture_enable = cap;
  assign timestamp_count = ts;
  assign rx_acceptance_mask_3 = mask3;
  assign filter_control = {fc[3], fc[2], fc[1], fc[0]};

  // Checks
  logic fc_touched;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_touched <= 1'b0;
    end else if (wr && sel == cts_pkg::cts_sel_fc) begin
      fc_touched <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TS_STEP: assert property (
    cap && tick && !tmr_wr |=> ts == $past(ts) + `CTS_ONE16 &&
      presc_cnt == `CTS_ZERO16)
    else $error("count did not advance on prescaler tick");
  AST_PRESC_SPACING: assert property (
    cap && !tmr_wr && prescale != `CTS_ZERO16 && $changed(ts) &&
      $stable(prescale) ##1 (cap && !tmr_wr && $stable(prescale))
      [*1] |-> presc_cnt == `CTS_ONE16 || prescale == `CTS_ONE16)
    else $error("prescaler count not restarted after step");
  AST_PAUSE: assert property (
    !cap && !tmr_wr |=> $stable(ts) && $stable(presc_cnt))
    else $error("timer moved while capture disabled");
  AST_WR_CLEARS_CNT: assert property (
    tmr_wr |=> presc_cnt == `CTS_ZERO16)
    else $error("timer write did not clear prescaler count");
  AST_TMR_READ: assert property (
    setup && !pwrite && sel == cts_pkg::cts_sel_tmr |=>
      prdata == {$past(ts), $past(prescale)})
    else $error("timer read data wrong");
  AST_OVF_SET: assert property (
    |rx_overflow_event |=> (ovf & $past(rx_overflow_event)) ==
      $past(rx_overflow_event) &&
      (int_stat & $past(rx_overflow_event)) == $past(rx_overflow_event))
    else $error("overflow event lost");
  AST_OVF_UPPER: assert property (
    access && !pwrite && sel == cts_pkg::cts_sel_ovf |->
      prdata[`CTS_HIGH_MSB:`CTS_HIGH_LSB] == `CTS_ZERO16)
    else $error("overflow upper half not zero");
  AST_SET_ALIAS: assert property (
    wr && sel == cts_pkg::cts_sel_fc && op == cts_pkg::cts_alias_set &&
      fc_idx == 2'b00 |=> fc[0] == ($past(fc[0]) | $past(pwdata)))
    else $error("set alias result wrong");
  AST_FC_RESET: assert property (
    !fc_touched |-> filter_control == '0)
    else $error("filter control not zero after reset");
  AST_WRAP: assert property (
    cap && tick && !tmr_wr && ts == `CTS_TS_MAX |=> ts == `CTS_ZERO16)
    else $error("count did not wrap to zero");

  COV_TICK: cover property (cap && tick && !tmr_wr);
  COV_WRAP: cover property (cap && tick && ts == `CTS_TS_MAX);
  COV_FID_WR: cover property (wr && sel == cts_pkg::cts_sel_fid);
  COV_IRQ: cover property ($rose(irq));

endmodule : cts_regs

// File: dv/test_cts_regs.sv
// Self-checking bench for the timer, overflow and filter register slice.
// Assumes cts_regs answers APB with no wait states; map from cts_defines.
`timescale 1ns/1ns
`include "cts_defines.svh"

module test_cts_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cap, irq;
  logic [15:0] paddr, ev, rel, ts, pe, r16;
  logic [31:0] pwdata, prdata, mask3, seed, m_mask3;
  logic [127:0] fc;
  logic [31:0] m_fc[4];
  logic [31:0] m_fid[16];
  logic [15:0] m_ts, m_pre, m_ovf, m_ist, m_imsk, m_fid_ok;
  logic m_cap, m_mask_ok;
  logic [33:0] rsp;
  int errors, n_compared, cycles, pcnt;
  logic [15:0] rd_tab[7] = '{`CTS_ADDR_CTRL, `CTS_ADDR_OVF, `CTS_ADDR_TMR,
    `CTS_ADDR_FC0, `CTS_ADDR_FC1, `CTS_ADDR_FC2, `CTS_ADDR_FC3};
  logic [15:0] wr_tab[8] = '{`CTS_ADDR_MASK3, `CTS_ADDR_FC0, `CTS_ADDR_FC1,
    `CTS_ADDR_FC2, `CTS_ADDR_FC3, `CTS_ADDR_FID0, 16'hb190, 16'hb230};
  logic [15:0] pre_tab[5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0007,
    16'hffff};

  cts_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_overflow_event(ev), .rx_overflow_release(rel),
    .timestamp_capture_enable(cap), .timestamp_count(ts),
    .rx_acceptance_mask_3(mask3), .filter_control(fc), .irq(irq));

  always #50 pclk = ~pclk;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] alias_op(logic [31:0] o, logic [31:0] d,
      logic [1:0] op);
    case (op)
      2'h0: return d;
      2'h1: return o & ~d;
      2'h2: return o | d;
      default: return o ^ d;
    endcase
  endfunction : alias_op

  // Model read: {not comparable, error, data}
  function automatic logic [33:0] m_read(logic [15:0] a);
    int i;
    i = int'((a - `CTS_ADDR_FID0) >> 4);
    case (a)
      `CTS_ADDR_CTRL: return {2'b00, 11'h000, m_cap, 20'h0_0000};
      `CTS_ADDR_OVF: return {2'b00, 16'h0000, m_ovf};
      `CTS_ADDR_TMR: return {2'b00, m_ts, m_pre};
      `CTS_ADDR_MASK3: return {!m_mask_ok, 1'b0, m_mask3};
      `CTS_ADDR_FC0, `CTS_ADDR_FC1, `CTS_ADDR_FC2, `CTS_ADDR_FC3:
        return {2'b00, m_fc[a[5:4]]};
      `CTS_ADDR_INT_STAT: return {2'b00, 16'h0000, m_ist};
      `CTS_ADDR_INT_MASK: return {2'b00, 16'h0000, m_imsk};
      default: begin
        if (a >= `CTS_ADDR_FID0 && a <= `CTS_ADDR_FID_LAST && a[3:0] == 0)
          return {!m_fid_ok[i], 1'b0, m_fid[i]};
        return {2'b01, 32'h0000_0000};
      end
    endcase
  endfunction : m_read

  task automatic m_write(input logic [15:0] a, input logic [31:0] d);
    logic [15:0] b;
    logic [33:0] o;
    logic [31:0] t;
    int i;
    b = a & `CTS_BASE_MASK;
    o = m_read(b);
    t = alias_op(o[31:0], d, a[3:2]);
    i = int'((b - `CTS_ADDR_FID0) >> 4);
    case (b)
      `CTS_ADDR_CTRL: m_cap = t[`CTS_CAP_BIT];
      `CTS_ADDR_TMR: begin
        {m_ts, m_pre} = t;
        pcnt = 0;
      end
      `CTS_ADDR_MASK3: begin
        m_mask3 = t;
        m_mask_ok = 1'b1;
      end
      `CTS_ADDR_FC0, `CTS_ADDR_FC1, `CTS_ADDR_FC2, `CTS_ADDR_FC3:
        m_fc[b[5:4]] = t;
      `CTS_ADDR_INT_STAT: if (a[3:2] == 2'h0) m_ist = m_ist & ~d[15:0];
      `CTS_ADDR_INT_MASK: if (a[3:2] == 2'h0) m_imsk = d[15:0];
      default: begin
        if (o[32] == 1'b0 && b >= `CTS_ADDR_FID0) begin
          m_fid[i] = t;
          m_fid_ok[i] = 1'b1;
        end
      end
    endcase
  endtask : m_write

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_cap = 1'b0;
      {m_ts, m_pre, m_ovf, m_ist, m_imsk, m_fid_ok} = '0;
      m_fc = '{default: 32'h0000_0000};
      m_mask_ok = 1'b0;
      pcnt = 0;
    end else begin
      if (psel && !penable && !pwrite) rsp = m_read(paddr);
      if (m_cap && !(psel && penable && pwrite &&
          (paddr & `CTS_BASE_MASK) == `CTS_ADDR_TMR)) begin
        pe = (m_pre == 16'h0000) ? 16'h0001 : m_pre;
        pcnt++;
        if (pcnt >= pe) begin
          pcnt = 0;
          m_ts = m_ts + 16'h0001;
        end
      end
      if (psel && penable && pwrite) m_write(paddr, pwdata);
      m_ovf = (m_ovf & ~rel) | ev;
      m_ist = m_ist | ev;
    end
  end

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: port %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  always @(negedge pclk) begin
    if (presetn) begin
      chk_port(ts, m_ts);
      chk_port(cap, m_cap);
      chk_port(irq, |(m_ist & m_imsk));
      if (m_mask_ok) chk_port(mask3, m_mask3);
      for (int k = 0; k < 4; k++) chk_port(fc[32*k +: 32], m_fc[k]);
    end
  end

  task automatic apb(input logic w, input logic [15:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) begin
      chk_rd(pslverr, rsp[32]);
      if (!rsp[33]) chk_rd(prdata, rsp[31:0]);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input logic [15:0] e, input logic [15:0] r);
    ev <= e;
    rel <= r;
    @(posedge pclk);
    ev <= 16'h0000;
    rel <= 16'h0000;
    @(posedge pclk);
  endtask : pulse

  task conclude();
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ev, rel} = '0;
    seed = 32'h0000_cb04;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rd_tab[k]) apb(1'b0, rd_tab[k], 32'h0000_0000);
    foreach (wr_tab[k]) begin
      for (int op = 0; op < 4; op++) begin
        apb(1'b1, wr_tab[k] + 16'(4 * op), rnd());
        apb(1'b0, wr_tab[k], 32'h0000_0000);
      end
    end
    apb(1'b1, 16'hb024, rnd());
    apb(1'b0, 16'hb024, 32'h0000_0000);
    apb(1'b0, 16'hb304, 32'h0000_0000);
    apb(1'b1, `CTS_ADDR_INT_MASK, rnd());
    repeat (4) begin
      r16 = rnd();
      pulse(r16, 16'h0000);
      apb(1'b0, `CTS_ADDR_OVF, 32'h0000_0000);
      apb(1'b1, `CTS_ADDR_OVF, 32'hffff_ffff);
      apb(1'b0, `CTS_ADDR_INT_STAT, 32'h0000_0000);
      apb(1'b1, `CTS_ADDR_INT_STAT, rnd());
      r16 = rnd();
      pulse(rnd(), r16);
      apb(1'b0, `CTS_ADDR_OVF, 32'h0000_0000);
    end
    foreach (pre_tab[k]) begin
      apb(1'b1, `CTS_ADDR_TMR, {16'hfffd, pre_tab[k]});
      apb(1'b1, `CTS_ADDR_CTRL + 16'h0008, 32'h0010_0000);
      repeat (int'(pre_tab[k]) + 8) @(posedge pclk);
      apb(1'b1, `CTS_ADDR_TMR + 16'h0008, 32'h0000_0000);
      repeat (8) @(posedge pclk);
      apb(1'b1, `CTS_ADDR_CTRL + 16'h0004, 32'h0010_0000);
      repeat (8) @(posedge pclk);
      apb(1'b0, `CTS_ADDR_TMR, 32'h0000_0000);
    end
    conclude();
  end
endmodule : test_cts_regs
